// File: logic/psw_flags.sv
`include "psw_params.svh"

module psw_flags (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// arithmetic datapath
	input wire logic op_valid,
	input wire psw_pkg::psw_op_t op_code,
	input wire logic [7:0] op_a,
	input wire logic [7:0] op_b,
	input wire logic [7:0] acc,
	// sfr bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic sfr_bit_val,
	input wire logic [4:0] reg_index,
	// results
	output logic [7:0] sfr_rdata,
	output logic [7:0] program_status_word,
	output logic [1:0] bank_select,
	output logic [7:0] reg_addr
);

	// ====================================================
	// reset release
	logic rst_meta, rst_sync_n;

	// two stages so release is glitch free
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ====================================================
	// arithmetic helpers
	function automatic logic [8:0] add9(input logic [7:0] a,
		input logic [7:0] b, input logic c);
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, c};
	endfunction

	function automatic logic [4:0] add5(input logic [3:0] a,
		input logic [3:0] b, input logic c);
		add5 = {1'b0, a} + {1'b0, b} + {4'h0, c};
	endfunction

	// ====================================================
	// flag state
	logic carry_flag, aux_carry_flag, overflow_flag;
	logic user_flag_a, user_flag_b;
	logic parity; // combinational from acc
	logic [7:0] psw_now; // assembled word
	logic sel; // status word addressed
	logic [8:0] sum; // byte result with carry
	logic [4:0] nib; // low nibble result
	logic [15:0] prod; // multiply product
	logic cin; // effective carry in
	logic next_cy, next_ac, next_ov, upd_cy, upd_ov;

	assign sel = (sfr_addr == `PSW_ADDR);
	assign parity = ^acc;
	assign psw_now = {carry_flag, aux_carry_flag, user_flag_a,
		bank_select, overflow_flag, user_flag_b, parity};
	assign prod = op_a * op_b;

	// flag results per operation
	always_comb begin
		cin = 1'b0;
		sum = 9'h000;
		nib = 5'h00;
		next_cy = 1'b0;
		next_ac = 1'b0;
		next_ov = 1'b0;
		upd_cy = 1'b0;
		upd_ov = 1'b0;
		case (op_code)
			psw_pkg::PSW_OP_ADD, psw_pkg::PSW_OP_ADDC: begin
				cin = (op_code == psw_pkg::PSW_OP_ADDC) & carry_flag;
				sum = add9(op_a, op_b, cin);
				nib = add5(op_a[3:0], op_b[3:0], cin);
				next_cy = sum[8];
				next_ac = nib[4];
				// same sign in, other sign out
				next_ov = (op_a[7] == op_b[7]) &&
					(sum[7] != op_a[7]);
				upd_cy = 1'b1;
				upd_ov = 1'b1;
			end
			psw_pkg::PSW_OP_SUBB: begin
				// subtract as a + ~b + ~borrow, borrow = !carry
				sum = add9(op_a, ~op_b, ~carry_flag);
				nib = add5(op_a[3:0], ~op_b[3:0], ~carry_flag);
				next_cy = ~sum[8];
				next_ac = ~nib[4];
				next_ov = (op_a[7] != op_b[7]) &&
					(sum[7] != op_a[7]);
				upd_cy = 1'b1;
				upd_ov = 1'b1;
			end
			psw_pkg::PSW_OP_MUL: begin
				// multiply and divide clear the carries
				next_ov = (prod > `PSW_MUL_MAX);
				upd_cy = 1'b1;
				upd_ov = 1'b1;
			end
			psw_pkg::PSW_OP_DIV: begin
				next_ov = (op_b == 8'h00);
				upd_cy = 1'b1;
				upd_ov = 1'b1;
			end
			psw_pkg::PSW_OP_OTHER: begin
				// other arithmetic clears both carries
				upd_cy = 1'b1;
			end
			default: begin
				upd_cy = 1'b0;
			end
		endcase
	end

	// ====================================================
	// carry flags: arithmetic wins over a software write
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			carry_flag <= 1'b0;
			aux_carry_flag <= 1'b0;
		end else if (op_valid && upd_cy) begin
			carry_flag <= next_cy;
			aux_carry_flag <= next_ac;
		end else if (sel && sfr_wr) begin
			carry_flag <= sfr_wdata[`PSW_BIT_CY];
			aux_carry_flag <= sfr_wdata[`PSW_BIT_AC];
		end else if (sel && sfr_bit_wr) begin
			if (sfr_bit_sel == `PSW_BIT_CY)
				carry_flag <= sfr_bit_val;
			if (sfr_bit_sel == `PSW_BIT_AC)
				aux_carry_flag <= sfr_bit_val;
		end
	end

	// overflow flag
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			overflow_flag <= 1'b0;
		end else if (op_valid && upd_ov) begin
			overflow_flag <= next_ov;
		end else if (sel && sfr_wr) begin
			overflow_flag <= sfr_wdata[`PSW_BIT_OV];
		end else if (sel && sfr_bit_wr &&
			sfr_bit_sel == `PSW_BIT_OV) begin
			overflow_flag <= sfr_bit_val;
		end
	end

	// user flags and bank select, software only
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			user_flag_a <= 1'b0;
			user_flag_b <= 1'b0;
			bank_select <= 2'h0;
		end else if (sel && sfr_wr) begin
			user_flag_a <= sfr_wdata[`PSW_BIT_UA];
			user_flag_b <= sfr_wdata[`PSW_BIT_UB];
			bank_select <= sfr_wdata[`PSW_BIT_RS1:`PSW_BIT_RS0];
		end else if (sel && sfr_bit_wr) begin
			case (sfr_bit_sel)
				`PSW_BIT_UA: user_flag_a <= sfr_bit_val;
				`PSW_BIT_UB: user_flag_b <= sfr_bit_val;
				`PSW_BIT_RS1: bank_select[1] <= sfr_bit_val;
				`PSW_BIT_RS0: bank_select[0] <= sfr_bit_val;
				default: user_flag_a <= user_flag_a;
			endcase
		end
	end

	// ====================================================
	// registered outputs; parity bit ignores writes
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			program_status_word <= `PSW_RESET;
			sfr_rdata <= 8'h00;
			reg_addr <= 8'h00;
		end else begin
			program_status_word <= psw_now;
			sfr_rdata <= sel ? psw_now : 8'h00;
			// bank base plus register number
			reg_addr <= {3'h0, bank_select,
				reg_index[2:0]};
		end
	end

	// ====================================================
	// checks
	property p_par;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		1'b1 |=> program_status_word[`PSW_BIT_PAR] == ^$past(acc);
	endproperty
	a_par: assert property (p_par) else $error("parity wrong");

	property p_mul;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		op_valid && op_code == psw_pkg::PSW_OP_MUL |=>
			overflow_flag == ($past(prod) > `PSW_MUL_MAX);
	endproperty
	a_mul: assert property (p_mul) else $error("mul ov");

	property p_div;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		op_valid && op_code == psw_pkg::PSW_OP_DIV && op_b == 8'h00
			|=> overflow_flag ##1 program_status_word[`PSW_BIT_OV];
	endproperty
	a_div: assert property (p_div) else $error("div ov");

	property p_add;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		op_valid && op_code == psw_pkg::PSW_OP_ADD |=>
			carry_flag == ({1'b0, $past(op_a)} +
				{1'b0, $past(op_b)} > 9'h0ff);
	endproperty
	a_add: assert property (p_add) else $error("add cy");

	property p_ac;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		op_valid && op_code == psw_pkg::PSW_OP_ADD |=>
			aux_carry_flag == ({1'b0, $past(op_a[3:0])} +
				{1'b0, $past(op_b[3:0])} > 5'h0f);
	endproperty
	a_ac: assert property (p_ac) else $error("aux carry");

	property p_ovclr;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		op_valid && op_code == psw_pkg::PSW_OP_DIV && op_b != 8'h00
			|=> !overflow_flag;
	endproperty
	a_ovclr: assert property (p_ovclr) else $error("ov clr");

	property p_sov;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		op_valid && op_code == psw_pkg::PSW_OP_ADD &&
			op_a == 8'h7f && op_b == 8'h01 |=> overflow_flag;
	endproperty
	a_sov: assert property (p_sov) else $error("signed ov");

	property p_user;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		!(sel && (sfr_wr || sfr_bit_wr)) |=>
			$stable(user_flag_a) && $stable(user_flag_b);
	endproperty
	a_user: assert property (p_user) else $error("user flag");

	property p_bank;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		1'b1 |=> reg_addr[4:3] == $past(bank_select);
	endproperty
	a_bank: assert property (p_bank) else $error("bank");

	property p_rd;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		sfr_addr == 8'hd0 |=> sfr_rdata == $past(psw_now);
	endproperty
	a_rd: assert property (p_rd) else $error("read");

	// subtract request as seen at the taking edge
	sequence s_op_subb;
		op_valid && op_code == psw_pkg::PSW_OP_SUBB;
	endsequence

	// other arithmetic request, which must clear both carries
	sequence s_op_other;
		op_valid && op_code == psw_pkg::PSW_OP_OTHER;
	endsequence

	// borrow when the subtrahend plus borrow in exceeds the minuend
	property p_subb;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		s_op_subb |=> carry_flag == ({1'b0, $past(op_a)} <
			{1'b0, $past(op_b)} + {8'h00, $past(carry_flag)});
	endproperty
	a_subb: assert property (p_subb) else $error("subb cy");

	property p_other;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		s_op_other |=> !carry_flag && !aux_carry_flag;
	endproperty
	a_other: assert property (p_other) else $error("clr cy");

	// bank field only moves on a software write to the word
	property p_bankhold;
		@(posedge clk_sys) disable iff (!rst_sync_n)
		!(sel && (sfr_wr || sfr_bit_wr)) |=> $stable(bank_select);
	endproperty
	a_bankhold: assert property (p_bankhold) else $error("bank hold");

endmodule

// File: logic/psw_params.svh
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

// ====================================================
// register map
`define PSW_ADDR 8'hd0
`define PSW_RESET 8'h00
// ====================================================
// field positions
`define PSW_BIT_CY 3'h7
`define PSW_BIT_AC 3'h6
`define PSW_BIT_UA 3'h5
`define PSW_BIT_RS1 3'h4
`define PSW_BIT_RS0 3'h3
`define PSW_BIT_OV 3'h2
`define PSW_BIT_UB 3'h1
`define PSW_BIT_PAR 3'h0
// ====================================================
// bank geometry and limits
`define PSW_BANK_SHIFT 3
`define PSW_MUL_MAX 16'h00ff

`endif

// File: logic/psw_pkg.sv
// ====================================================
// operation codes from the arithmetic datapath
package psw_pkg;
	typedef enum logic [2:0] {
		PSW_OP_NONE,
		PSW_OP_ADD,
		PSW_OP_ADDC,
		PSW_OP_SUBB,
		PSW_OP_MUL,
		PSW_OP_DIV,
		PSW_OP_OTHER
	} psw_op_t;
endpackage

// File: testbench/program_status_flags_tb_top.sv
module program_status_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ====================================================
	// design ports
	logic clk_sys, reset_n, op_valid, sfr_wr, sfr_bit_wr, sfr_bit_val;
	psw_pkg::psw_op_t op_code;
	logic [7:0] op_a, op_b, acc, sfr_addr, sfr_wdata;
	logic [2:0] sfr_bit_sel;
	logic [4:0] reg_index;
	logic [7:0] sfr_rdata, program_status_word, reg_addr;
	logic [1:0] bank_select;
	// model word; bit 0 unused, parity comes from acc
	logic [7:0] m_psw;
	logic [31:0] seed = 32'h00000056;
	int error_cnt = 0;
	int samples_checked = 0;

	always #5 clk_sys = ~clk_sys;

	psw_flags i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b),
		.acc(acc), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
		.sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
		.reg_index(reg_index), .sfr_rdata(sfr_rdata),
		.program_status_word(program_status_word),
		.bank_select(bank_select), .reg_addr(reg_addr));

	// ====================================================
	// helpers
	// xorshift keeps the run repeatable from one seed
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// drop pulses after one edge, then wait out the two-stage latency
	task automatic run();
		logic [7:0] e;
		@(posedge clk_sys);
		#1;
		op_valid = 0;
		sfr_wr = 0;
		sfr_bit_wr = 0;
		repeat (2) @(posedge clk_sys);
		#1;
		e = {m_psw[7:1], ^acc};
		chk("status word", e, program_status_word);
		chk("bank", {6'h00, e[4:3]}, {6'h00, bank_select});
		chk("reg addr", {3'h0, e[4:3], reg_index[2:0]}, reg_addr);
		chk("rdata", (sfr_addr == 8'hd0) ? e : 8'h00, sfr_rdata);
	endtask

	// arithmetic step with the flag model worked alongside
	task automatic do_op(psw_pkg::psw_op_t op, logic [7:0] a, logic [7:0] b);
		int c, r, n;
		c = (op == psw_pkg::PSW_OP_ADD) ? 0 : int'(m_psw[7]);
		op_code = op;
		op_a = a;
		op_b = b;
		op_valid = 1;
		r = a + b + c;
		n = a[3:0] + b[3:0] + c;
		if (op == psw_pkg::PSW_OP_ADD || op == psw_pkg::PSW_OP_ADDC) begin
			m_psw[7] = r > 255;
			m_psw[6] = n > 15;
			m_psw[2] = a[7] == b[7] && r[7] != a[7];
		end else if (op == psw_pkg::PSW_OP_SUBB) begin
			r = a - b - c;
			n = a[3:0] - b[3:0] - c;
			m_psw[7] = r < 0;
			m_psw[6] = n < 0;
			m_psw[2] = a[7] != b[7] && r[7] != a[7];
		end else begin
			// every other arithmetic op clears both carries
			m_psw[7] = 0;
			m_psw[6] = 0;
			if (op == psw_pkg::PSW_OP_MUL)
				m_psw[2] = a * b > 255;
			if (op == psw_pkg::PSW_OP_DIV)
				m_psw[2] = b == 8'h00;
		end
		run();
	endtask

	task automatic wr_byte(logic [7:0] adr, logic [7:0] d);
		sfr_addr = adr;
		sfr_wdata = d;
		sfr_wr = 1;
		// bit 0 is parity, so a write there must not land
		if (adr == 8'hd0) m_psw[7:1] = d[7:1];
		run();
	endtask

	task automatic wr_bit(logic [7:0] adr, logic [2:0] s, logic v);
		sfr_addr = adr;
		sfr_bit_sel = s;
		sfr_bit_val = v;
		sfr_bit_wr = 1;
		if (adr == 8'hd0 && s != 3'h0) m_psw[s] = v;
		run();
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// guard against a hang
	initial begin
		#200us;
		error_cnt++;
		close_out();
	end

	// ====================================================
	// main sequence
	initial begin
		{clk_sys, reset_n, op_valid, sfr_wr, sfr_bit_wr, sfr_bit_val} = '0;
		op_code = psw_pkg::PSW_OP_NONE;
		{op_a, op_b, acc, sfr_wdata, sfr_bit_sel, reg_index} = '0;
		sfr_addr = 8'hd0;
		m_psw = 8'h00;
		repeat (10) @(posedge clk_sys);
		#1;
		reset_n = 1;
		repeat (3) @(posedge clk_sys);
		#1;
		run();
		do_op(psw_pkg::PSW_OP_ADD, 8'h7f, 8'h01);
		do_op(psw_pkg::PSW_OP_MUL, 8'h0f, 8'h11);
		do_op(psw_pkg::PSW_OP_MUL, 8'h10, 8'h10);
		do_op(psw_pkg::PSW_OP_DIV, 8'h12, 8'h00);
		do_op(psw_pkg::PSW_OP_DIV, 8'h12, 8'h03);
		wr_byte(8'hd0, 8'hff);
		do_op(psw_pkg::PSW_OP_OTHER, 8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			acc = 8'(rnd());
			wr_bit(8'hd0, 3'(i), ~m_psw[i]);
		end
		for (int k = 0; k < 4; k++) begin
			reg_index = 5'(rnd());
			wr_byte(8'hd0, {3'h0, 2'(k), 3'h0});
		end
		// random mix; carry from writes feeds addc and subb
		for (int i = 0; i < 300; i++) begin
			acc = 8'(rnd());
			reg_index = 5'(rnd());
			case (rnd() % 4)
				0: wr_byte((rnd() % 8 == 0) ? 8'hd1 : 8'hd0, 8'(rnd()));
				1: wr_bit(8'hd0, 3'(rnd()), 1'(rnd()));
				default: do_op(psw_pkg::psw_op_t'(3'(1 + rnd() % 6)), 8'(rnd()),
					(rnd() % 5 == 0) ? 8'h00 : 8'(rnd()));
			endcase
		end
		close_out();
	end
endmodule
